// *** bench/iop_board.sv ***
// Purpose: Board model of the eight port pins
// Assumes: Pin levels settle within one clock
// Notes: A pin nobody drives or pulls toggles, so a stale level never reads valid
`timescale 1ns/1ps
module iop_board (
  input wire logic clk_i,
  input wire logic [7:0] dev_out_i,
  input wire logic [7:0] dev_oe_i,
  input wire logic [7:0] dev_pull_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] level_o
);
  logic flt = 1'b0;
  // Floating pattern flips every cycle
  always @(posedge clk_i) begin
    flt <= ~flt;
  end
  // Device driver first, then board source, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe_i[i]) begin
        level_o[i] = dev_out_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_val_i[i];
      end else if (dev_pull_i[i]) begin
        level_o[i] = 1'b1;
      end else begin
        level_o[i] = flt;
      end
    end
  end
endmodule

// *** bench/iop_port_tb.sv ***
// Purpose: Self-checking bench of the I/O port
// Assumes: Registers reached over classic Wishbone, byte offsets 0x00 to 0x14
// Notes: Pins are checked a few cycles after each write, once outputs have settled
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module iop_port_tb;
  import iop_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, uart_rx_o, s0_in_o, s1_in_o;
  iop_func_t fn = '0;
  logic [7:0] pin_i, pin_o, pin_oe_o, pullup_en_o, ana_conn_o;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
  logic [15:0] ana_line_o;
  logic [4:0] ofs [6] = '{5'h00, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
  int bad_count = 0, n_checks = 0;
  always #5 clk_i = ~clk_i;
  iop_port u_iop_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .func_i(fn), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o), .ana_conn_o(ana_conn_o),
    .ana_line_o(ana_line_o), .uart_rx_o(uart_rx_o), .s0_in_o(s0_in_o), .s1_in_o(s1_in_o));
  iop_board u_iop_board (.clk_i(clk_i), .dev_out_i(pin_o), .dev_oe_i(pin_oe_o),
    .dev_pull_i(pullup_en_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare with case equality so an unknown never matches
  function automatic void chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 4'h1, q);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 8'h00, 4'hF, r);
    chk($sformatf("reg %0h", a), e, r);
  endtask
  // Wait past the pin update and the two-flop input sync
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  task automatic ext(input logic [7:0] en, input logic [7:0] v);
    @(posedge clk_i);
    ext_en <= en;
    ext_val <= v;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (11) @(posedge clk_i);
    #1;
    `CHK("rx", 1, uart_rx_o);
    @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rc(ofs[i], 0);
    #1;
    `CHK("oe", 0, pin_oe_o | ana_conn_o);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 8'hA5);
      rc(ofs[i], 32'hA5);
    end
    wr(5'h14, 8'hFF);
    rc(5'h14, 32'h0F);
    wb(1'b1, 5'h00, 8'h3C, 4'h0, q);
    rc(5'h00, 32'hA5);
    // Push-pull outputs: pull-ups off whatever the register holds
    wr(5'h14, 8'h00);
    wr(5'h0C, 8'h00);
    wr(5'h08, 8'hFF);
    wr(5'h10, 8'hFF);
    settle();
    `CHK("oe", 8'hFF, pin_oe_o);
    `CHK("out", 8'hA5, pin_o);
    `CHK("pull", 8'h00, pullup_en_o);
    rc(5'h04, 32'hA5);
    // Open drain: low bits driven, high bits released and pulled
    wr(5'h0C, 8'hFF);
    settle();
    `CHK("oe", 8'h5A, pin_oe_o);
    `CHK("out", 8'h00, pin_o & pin_oe_o);
    `CHK("pull", 8'hA5, pullup_en_o);
    rc(5'h04, 32'hA5);
    // Inputs: driver off, pull-ups on, board levels read back
    wr(5'h08, 8'h00);
    ext(8'hFF, 8'h3C);
    settle();
    `CHK("oe", 8'h00, pin_oe_o);
    `CHK("pull", 8'hFF, pullup_en_o);
    rc(5'h04, 32'h3C);
    `CHK("rx", 0, uart_rx_o);
    // Functions override digital settings; order pwm0..uart_tx, then enables
    ext(8'h80, 8'h00);
    fn <= {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'hFF};
    settle();
    `CHK("oe", 8'h5F, pin_oe_o);
    `CHK("out", 8'h45, pin_o & pin_oe_o);
    `CHK("pull", 8'hA0, pullup_en_o);
    `CHK("s0s1", 2'b10, {s1_in_o, s0_in_o});
    `CHK("rx", 0, uart_rx_o);
    // Analog pairs set up in the safe order; functions stay enabled
    wr(5'h10, 8'h00);
    wr(5'h14, 8'h0F);
    wr(5'h08, 8'h1B);
    wr(5'h00, 8'hE4);
    wr(5'h10, 8'hFF);
    settle();
    `CHK("conn", 8'hFF, ana_conn_o);
    `CHK("line", 16'hC963, ana_line_o);
    `CHK("oe", 8'h00, pin_oe_o | pullup_en_o);
    `CHK("s0", 1, s0_in_o & s1_in_o & uart_rx_o);
    wr(5'h14, 8'h05);
    wr(5'h10, 8'h0F);
    settle();
    `CHK("conn", 8'h03, ana_conn_o);
    `CHK("line", 4'h3, ana_line_o[3:0]);
    `CHK("oe", 8'h4C, pin_oe_o);
    // Reset in mid-run clears every register
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rc(ofs[i], 0);
    settle();
    `CHK("conn", 0, ana_conn_o);
    print_verdict();
  end
endmodule

// *** rtl/iop_consts.svh ***
// Purpose: Offsets, field positions and reset values of the I/O port
// Assumes: Byte offsets on a 32-bit classic Wishbone bus
// Notes: Definitions only
`ifndef IOP_CONSTS_SVH
`define IOP_CONSTS_SVH
`define IOP_ADDR_W 4
`define IOP_OFS_OUT 4'h0
`define IOP_OFS_IN 4'h4
`define IOP_OFS_DIR 4'h8
`define IOP_OFS_DRV 4'hC
`define IOP_OFS_PULL 4'h0
`define IOP_OFS_ANA 4'h4
`define IOP_PAGE_HI 1'b1
`define IOP_RST_BYTE 8'h00
`define IOP_RST_ANA 4'h0
`define IOP_ANA_BITS 4
`define IOP_LINES 4
`endif

// *** rtl/iop_pin_mux.sv ***
// Purpose: Per-pin priority selection between analog, function and digital use
// Assumes: Register values come from flip-flops on the same clock
// Notes: Purely combinational; top registers its outputs
`timescale 1ns/1ps
`include "iop_consts.svh"
module iop_pin_mux (
  input wire logic [7:0] out_value_i,
  input wire logic [7:0] direction_i,
  input wire logic [7:0] drive_type_i,
  input wire logic [7:0] pullup_i,
  input wire logic [3:0] analog_pairs_i,
  input wire iop_pkg::iop_func_t func_i,
  output iop_pkg::iop_pad_t pad_o
);
  import iop_pkg::*;

  // Function value carried by each pin when its function is on
  function automatic logic [7:0] func_values(input iop_func_t f);
    func_values = {1'b0, f.uart_tx, f.s1_out, f.s0_out, f.clk_32k, f.cpu_clk, f.pwm1, f.pwm0};
  endfunction

  logic [7:0] fval;
  assign fval = func_values(func_i);

  ///////////////////////////////////////////////////////////////////////////
  // Pin decisions; analog beats function beats digital
  always_comb begin
    pad_o = '0;
    for (int i = 0; i < 8; i++) begin
      logic ana;
      logic od;
      logic drv;
      ana = analog_pairs_i[i/2];
      od = 1'b0;
      drv = 1'b0;
      if (ana) begin
        pad_o.ana_conn[i] = pullup_i[i];
        // Both pins of a pair read their select bits at the pair's own index, never off the ends
        if (i % 2 == 1) begin
          pad_o.ana_line[2*i +: 2] = out_value_i[2*(i/2) +: 2];
        end else begin
          pad_o.ana_line[2*i +: 2] = direction_i[2*(i/2) +: 2];
        end
      end else if (func_i.fn_en[i]) begin
        // s0 and s1 lines (pins four and five) force open-drain; uart_tx pin is push-pull; rx pin is input only
        if (i == 4 || i == 5) begin
          od = 1'b1;
          drv = ~fval[i];
          pad_o.pull[i] = pullup_i[i] & fval[i];
        end else if (i != 7) begin
          drv = 1'b1;
          pad_o.dout[i] = fval[i];
        end else begin
          pad_o.pull[i] = pullup_i[i];
        end
        pad_o.oe[i] = drv;
      end else begin
        od = drive_type_i[i];
        if (direction_i[i]) begin
          if (od) begin
            pad_o.oe[i] = ~out_value_i[i];
            pad_o.pull[i] = pullup_i[i] & out_value_i[i];
          end else begin
            pad_o.oe[i] = 1'b1;
            pad_o.dout[i] = out_value_i[i];
            pad_o.pull[i] = 1'b0;
          end
        end else begin
          pad_o.pull[i] = pullup_i[i];
        end
      end
    end
  end
endmodule

// *** rtl/iop_pkg.sv ***
// Purpose: Types shared by the I/O port files
// Assumes: Eight pins, four analog lines
// Notes: Constants live in iop_consts.svh
package iop_pkg;
  typedef enum logic [1:0] {IOP_USE_DIGITAL, IOP_USE_FUNC, IOP_USE_ANALOG} iop_use_t;
  // Peripheral side of the pins: drive values, function enables
  typedef struct packed {
    logic pwm0;
    logic pwm1;
    logic cpu_clk;
    logic clk_32k;
    logic s0_out;
    logic s1_out;
    logic uart_tx;
    logic [7:0] fn_en;
  } iop_func_t;
  // Drive of one group of pins
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] dout;
    logic [7:0] pull;
    logic [7:0] ana_conn;
    logic [15:0] ana_line;
  } iop_pad_t;
endpackage

// *** rtl/iop_port.sv ***
// Purpose: Eight-pin I/O port with analog bus switching, Wishbone slave
// Assumes: Pins are foreign to clk_i; config reset arrives as rst_i
// Notes: Open-drain and tristate are expressed through pin_oe_o
//
// Function
// - Output register drives pins, resets zero
// - Input register reports sampled pin levels
// - Direction register: one means output
// - Drive type: one means open drain
// - Pull-up register enables pin pull-up
// - Four analog pair bits, upper read zero
// - Port reset clears every port register
// - Analog pair ignores function and digital
// - Enabled function overrides digital output
// - Otherwise plain digital, default after reset
// - Pin two CPU clock, three slow clock
// - Pins zero and one carry PWM
// - Serial pins four to seven
// - Open drain low disables pull-up
// - Analog pull-up bit connects the line
// - Odd pin line from output bits
// - Even pin line from direction bits
// - Four shared analog lines, any pin
// - Input pin output driver stays off
// - Open drain only drives low
// - Push-pull outputs never pulled up
`timescale 1ns/1ps
`include "iop_consts.svh"
module iop_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire iop_pkg::iop_func_t func_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_en_o,
  output logic [7:0] ana_conn_o,
  output logic [15:0] ana_line_o,
  output logic uart_rx_o,
  output logic s0_in_o,
  output logic s1_in_o
);
  import iop_pkg::*;

  initial begin
    if (`IOP_ANA_BITS * 2 != 8 || `IOP_LINES != 4) begin
      $error("iop_port supports eight pins on four lines only");
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] out_value_bits;
  logic [7:0] direction_bits;
  logic [7:0] drive_type_bits;
  logic [7:0] pullup_connect_bits;
  logic [3:0] analog_pair_bits;
  logic [7:0] in_sync1;
  logic [7:0] in_level_bits;
  logic [31:0] rd_data;
  logic ack;
  logic [7:0] next_out_value_bits;
  logic [7:0] next_direction_bits;
  logic [7:0] next_drive_type_bits;
  logic [7:0] next_pullup_connect_bits;
  logic [3:0] next_analog_pair_bits;
  logic [31:0] next_rd_data;
  logic next_ack;
  iop_pad_t pad;
  iop_pad_t pad_q;

  // Register index decode; bit 4 picks the second page
  function automatic logic hit(input logic [4:0] adr, input logic page, input logic [3:0] ofs);
    hit = (adr[4] == page) && (adr[3:0] == ofs);
  endfunction

  logic req;
  logic wr;
  assign req = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = req & wb_we_i & wb_sel_i[0];

  ///////////////////////////////////////////////////////////////////////////
  // Next register values; ack one cycle after request, so one-wait-state
  always_comb begin
    next_out_value_bits = out_value_bits;
    next_direction_bits = direction_bits;
    next_drive_type_bits = drive_type_bits;
    next_pullup_connect_bits = pullup_connect_bits;
    next_analog_pair_bits = analog_pair_bits;
    next_ack = req;
    next_rd_data = rd_data;
    if (wr) begin
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_OUT)) next_out_value_bits = wb_dat_i[7:0];
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_DIR)) next_direction_bits = wb_dat_i[7:0];
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_DRV)) next_drive_type_bits = wb_dat_i[7:0];
      if (hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_PULL)) next_pullup_connect_bits = wb_dat_i[7:0];
      if (hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_ANA)) next_analog_pair_bits = wb_dat_i[3:0];
    end
    if (req && !wb_we_i) begin
      // Unmapped words read zero rather than erroring
      next_rd_data = 32'h0000_0000;
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_OUT)) next_rd_data[7:0] = out_value_bits;
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_IN)) next_rd_data[7:0] = in_level_bits;
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_DIR)) next_rd_data[7:0] = direction_bits;
      if (hit(wb_adr_i, 1'b0, `IOP_OFS_DRV)) next_rd_data[7:0] = drive_type_bits;
      if (hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_PULL)) next_rd_data[7:0] = pullup_connect_bits;
      if (hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_ANA)) next_rd_data[3:0] = analog_pair_bits;
    end
  end

  // Port reset clears all configuration state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_value_bits <= `IOP_RST_BYTE;
      direction_bits <= `IOP_RST_BYTE;
      drive_type_bits <= `IOP_RST_BYTE;
      pullup_connect_bits <= `IOP_RST_BYTE;
      analog_pair_bits <= `IOP_RST_ANA;
      rd_data <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      out_value_bits <= next_out_value_bits;
      direction_bits <= next_direction_bits;
      drive_type_bits <= next_drive_type_bits;
      pullup_connect_bits <= next_pullup_connect_bits;
      analog_pair_bits <= next_analog_pair_bits;
      rd_data <= next_rd_data;
      ack <= next_ack;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Pin input synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_sync1 <= 8'h00;
      in_level_bits <= 8'h00;
    end else begin
      in_sync1 <= pin_i;
      in_level_bits <= in_sync1;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Priority mux, registered so outputs come from flops
  iop_pin_mux u_mux (
    .out_value_i(out_value_bits),
    .direction_i(direction_bits),
    .drive_type_i(drive_type_bits),
    .pullup_i(pullup_connect_bits),
    .analog_pairs_i(analog_pair_bits),
    .func_i(func_i),
    .pad_o(pad)
  );

  // One flop stage: writes reach pins the cycle after the register updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad;
    end
  end

  assign pin_o = pad_q.dout;
  assign pin_oe_o = pad_q.oe;
  assign pullup_en_o = pad_q.pull;
  assign ana_conn_o = pad_q.ana_conn;
  assign ana_line_o = pad_q.ana_line;
  assign wb_dat_o = rd_data;
  assign wb_ack_o = ack;

  // Serial inputs seen by peripherals, from synchronised levels; held high when analog
  logic [2:0] next_fin;
  logic [2:0] fin;
  always_comb begin
    next_fin = {in_level_bits[7], in_level_bits[5], in_level_bits[4]};
    if (analog_pair_bits[3]) next_fin[2] = 1'b1;
    if (analog_pair_bits[2]) next_fin[1:0] = 2'b11;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fin <= 3'b111;
    end else begin
      fin <= next_fin;
    end
  end
  assign uart_rx_o = fin[2];
  assign s1_in_o = fin[1];
  assign s0_in_o = fin[0];

  ///////////////////////////////////////////////////////////////////////////
  // Checks; a write lands at the taking edge, the pins follow one edge later

  // Bus handshake and register writes
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack held too long");
  a_out_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(wb_adr_i, 1'b0, `IOP_OFS_OUT)
    |=> out_value_bits == $past(wb_dat_i[7:0]))
    else $error("output write lost");
  a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(wb_adr_i, 1'b0, `IOP_OFS_DIR)
    |=> direction_bits == $past(wb_dat_i[7:0]))
    else $error("direction write lost");
  a_drv_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(wb_adr_i, 1'b0, `IOP_OFS_DRV)
    |=> drive_type_bits == $past(wb_dat_i[7:0]))
    else $error("drive type write lost");
  a_pull_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_PULL)
    |=> pullup_connect_bits == $past(wb_dat_i[7:0]))
    else $error("pull-up write lost");
  a_ana_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_ANA)
    |=> analog_pair_bits == $past(wb_dat_i[3:0]))
    else $error("analog pair write lost");
  a_sel_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && !wb_sel_i[0]
    |=> $stable({out_value_bits, direction_bits, drive_type_bits, pullup_connect_bits, analog_pair_bits}))
    else $error("masked write landed");

  // Readback; read data is captured at the taking edge
  a_out_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !$past(wb_we_i) && $past(hit(wb_adr_i, 1'b0, `IOP_OFS_OUT))
    |-> wb_dat_o == {24'h00_0000, $past(out_value_bits)})
    else $error("output readback wrong");
  a_in_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !$past(wb_we_i) && $past(hit(wb_adr_i, 1'b0, `IOP_OFS_IN))
    |-> wb_dat_o == {24'h00_0000, $past(in_level_bits)})
    else $error("input readback wrong");
  a_ana_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !$past(wb_we_i) && $past(hit(wb_adr_i, `IOP_PAGE_HI, `IOP_OFS_ANA))
    |-> wb_dat_o[31:4] == 28'h000_0000)
    else $error("analog upper bits nonzero");
  a_in_two_flops: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> ##2 in_level_bits == $past(pin_i, 2))
    else $error("input sample wrong");

  // Reset; these run while reset is high, so they carry no disable
  a_reset_clear: assert property (@(posedge clk_i)
    rst_i
    |=> out_value_bits == `IOP_RST_BYTE && direction_bits == `IOP_RST_BYTE && drive_type_bits == `IOP_RST_BYTE
      && pullup_connect_bits == `IOP_RST_BYTE && analog_pair_bits == `IOP_RST_ANA)
    else $error("reset left a register set");
  a_reset_pins: assert property (@(posedge clk_i)
    rst_i
    |=> pin_oe_o == 8'h00 && ana_conn_o == 8'h00 && uart_rx_o && s0_in_o && s1_in_o)
    else $error("pins not idle in reset");

  // Analog use beats everything else on its pair
  a_ana_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[0]
    |=> pin_oe_o[1:0] == 2'b00 && pullup_en_o[1:0] == 2'b00)
    else $error("analog pin driven");
  a_pair3_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[3]
    |=> pin_oe_o[7:6] == 2'b00 && pullup_en_o[7:6] == 2'b00)
    else $error("analog serial pin driven");
  a_rx_analog: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[3]
    |=> uart_rx_o)
    else $error("receiver saw analog pin");
  a_ana_conn: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[0]
    |=> ana_conn_o[1:0] == $past(pullup_connect_bits[1:0]))
    else $error("analog connect wrong");
  a_odd_line: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[1]
    |=> ana_line_o[7:6] == $past(out_value_bits[3:2]))
    else $error("odd line select wrong");
  a_even_line: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[1]
    |=> ana_line_o[5:4] == $past(direction_bits[3:2]))
    else $error("even line select wrong");
  a_digital_line: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[3]
    |=> ana_conn_o[7:6] == 2'b00 && ana_line_o[15:12] == 4'h0)
    else $error("digital pin on analog bus");

  // Functions beat digital settings
  a_pwm_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[0] && func_i.fn_en[1:0] == 2'b11
    |=> pin_oe_o[1:0] == 2'b11 && pin_o[1:0] == $past({func_i.pwm1, func_i.pwm0}))
    else $error("pwm not on pins");
  a_clk_pins: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[1] && func_i.fn_en[3:2] == 2'b11
    |=> pin_oe_o[3:2] == 2'b11 && pin_o[3:2] == $past({func_i.clk_32k, func_i.cpu_clk}))
    else $error("clocks not on pins");
  a_serial_od: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[2] && func_i.fn_en[4]
    |=> !pin_o[4] && pin_oe_o[4] == !$past(func_i.s0_out))
    else $error("serial line drove high");
  a_uart_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[3] && func_i.fn_en[6]
    |=> pin_oe_o[6] && pin_o[6] == $past(func_i.uart_tx))
    else $error("transmit not on pin");
  a_rx_input: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[3] && func_i.fn_en[7]
    |=> !pin_oe_o[7] && pullup_en_o[7] == $past(pullup_connect_bits[7]))
    else $error("receive pin driven");

  // Plain digital pins
  a_input_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits == 4'h0 && func_i.fn_en == 8'h00 && direction_bits == 8'h00
    |=> pin_oe_o == 8'h00)
    else $error("input pin driven");
  a_pp_out: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[0] && !func_i.fn_en[1] && direction_bits[1] && !drive_type_bits[1]
    |=> pin_oe_o[1] && pin_o[1] == $past(out_value_bits[1]))
    else $error("output value not on pin");
  a_od_low_only: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[0] == 1'b0 && !func_i.fn_en[0] && direction_bits[0] && drive_type_bits[0]
    |=> pin_o[0] == 1'b0 && pin_oe_o[0] == !$past(out_value_bits[0]))
    else $error("open drain drove high");
  a_od_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[0] && !func_i.fn_en[1] && direction_bits[1] && drive_type_bits[1] && !out_value_bits[1]
    |=> pin_oe_o[1] && !pin_o[1] && !pullup_en_o[1])
    else $error("pull-up on driven low");
  a_pp_no_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    analog_pair_bits[1] == 1'b0 && !func_i.fn_en[3] && direction_bits[3] && !drive_type_bits[3]
    |=> !pullup_en_o[3])
    else $error("push-pull pulled up");
  a_in_pull: assert property (@(posedge clk_i) disable iff (rst_i)
    !analog_pair_bits[3] && !func_i.fn_en[7] && !direction_bits[7]
    |=> !pin_oe_o[7] && pullup_en_o[7] == $past(pullup_connect_bits[7]))
    else $error("input pull-up wrong");

  // Main scenarios
  c_read: cover property (@(posedge clk_i) wb_ack_o && !$past(wb_we_i));
  c_analog: cover property (@(posedge clk_i) ana_conn_o != 0);
  c_func: cover property (@(posedge clk_i) func_i.fn_en[2] && pin_oe_o[2]);
  c_od_low: cover property (@(posedge clk_i) drive_type_bits[1] && direction_bits[1] && pin_oe_o[1]);
  c_mid_reset: cover property (@(posedge clk_i) $fell(rst_i));
endmodule
